// ---- rtl/lmw_move_core.sv ----
/*
 Execution core for literal loads and working-register stores, with an
 AXI4-Lite register slave. Writing the instruction register executes
 one instruction at the edge that commits the write.
 Assumes a single clock and a data memory fed by the mem* write port.
*/
// Summary of operation
// - Bank literal goes into the bank selector; no flag changes.
// - Seven-bit literal goes into the program-counter high latch; flags kept.
// - Eight-bit literal goes into the working register in one cycle.
// - Working register is copied to a seven-bit file address in one cycle.
// - Indirect store picks a pointer and pre/post increments or decrements it.
// - Relative form stores at pointer plus signed offset; pointer unchanged.
// - Indirect access ports 0 and 1 have no storage; each access goes where its pointer points.
// - Pointers are sixteen bits and wrap both ways.
// - Pointer updates and indirect stores leave all flags untouched.
`timescale 1ns/100ps
`default_nettype none
module lmw_move_core (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             memWe,
   output logic [15:0]      memAddr,
   output logic [7:0]       memData
);

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= lmw_pkg::REG_MEMWR);
   endfunction

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] val,
                                              input logic [3:0]  strb);
      for (int i = 0; i < 4; i++) begin
         mergeBytes[i*8 +: 8] = strb[i] ? val[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   logic        awHeld, next_awHeld;
   logic [7:0]  awAddrQ, next_awAddrQ;
   logic        wHeld, next_wHeld;
   logic [31:0] wDataQ, next_wDataQ;
   logic [3:0]  wStrbQ, next_wStrbQ;
   logic        next_awready, next_wready, next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_arready, next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   logic [7:0]  working, next_working;
   logic [4:0]  bankSelector, next_bankSelector;
   logic [6:0]  programCounterHighLatch, next_programCounterHighLatch;
   logic [15:0] indirectPointer [2];
   logic [15:0] next_indirectPointer [2];
   logic [7:0]  flags, next_flags;
   logic        next_memWe;
   logic [15:0] next_memAddr;
   logic [7:0]  next_memData;

   logic        doWrite;
   logic        execNow;
   logic [15:0] instr;
   logic [3:0]  execOp;
   logic        ptrSel;
   logic [6:0]  fileAddr;
   logic [31:0] merged;

   lmw_ptr_if ptrBus ();

   lmw_pointer_unit ptrUnit (
      .p (ptrBus.unit)
   );

   assign ptrBus.pointer           = indirectPointer[ptrSel];
   assign ptrBus.pointerUpdateMode = lmw_pkg::lmw_mode_e'(instr[1:0]);
   assign ptrBus.relative          = (execOp == lmw_pkg::OP_STORE_REL);
   assign ptrBus.offset            = instr[5:0];

   always_comb begin
      doWrite  = awHeld && wHeld && !s_axi_bvalid;
      merged   = mergeBytes(32'h00000000, wDataQ, wStrbQ);
      instr    = merged[15:0];
      execOp   = instr[lmw_pkg::OP_LSB +: 4];
      ptrSel   = instr[lmw_pkg::PTR_SEL_BIT];
      fileAddr = instr[6:0];
      execNow  = doWrite && (awAddrQ == lmw_pkg::REG_INSTR);
   end

   // Write channel and instruction execution
   always_comb begin
      next_awHeld  = awHeld;
      next_awAddrQ = awAddrQ;
      next_wHeld   = wHeld;
      next_wDataQ  = wDataQ;
      next_wStrbQ  = wStrbQ;
      next_bvalid  = s_axi_bvalid && !s_axi_bready;
      next_bresp   = s_axi_bresp;
      next_working = working;
      next_bankSelector = bankSelector;
      next_programCounterHighLatch = programCounterHighLatch;
      next_indirectPointer = indirectPointer;
      next_flags   = flags;
      next_memWe   = 1'b0;
      next_memAddr = memAddr;
      next_memData = memData;
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld  = 1'b1;
         next_awAddrQ = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld  = 1'b1;
         next_wDataQ = s_axi_wdata;
         next_wStrbQ = s_axi_wstrb;
      end
      if (doWrite) begin
         next_awHeld = 1'b0;
         next_wHeld  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = mapped(awAddrQ) ? lmw_pkg::RESP_OKAY : lmw_pkg::RESP_SLVERR;
         unique case (awAddrQ)
            lmw_pkg::REG_WORKING:
               next_working = wStrbQ[0] ? wDataQ[7:0] : working;
            lmw_pkg::REG_BANK:
               next_bankSelector = wStrbQ[0] ? wDataQ[4:0] : bankSelector;
            lmw_pkg::REG_PCLATCH:
               next_programCounterHighLatch = wStrbQ[0] ? wDataQ[6:0] : programCounterHighLatch;
            lmw_pkg::REG_PTR0:
               next_indirectPointer[0] = {wStrbQ[1] ? wDataQ[15:8] : indirectPointer[0][15:8],
                                          wStrbQ[0] ? wDataQ[7:0] : indirectPointer[0][7:0]};
            lmw_pkg::REG_PTR1:
               next_indirectPointer[1] = {wStrbQ[1] ? wDataQ[15:8] : indirectPointer[1][15:8],
                                          wStrbQ[0] ? wDataQ[7:0] : indirectPointer[1][7:0]};
            lmw_pkg::REG_FLAGS:
               next_flags = wStrbQ[0] ? wDataQ[7:0] : flags;
            default: ;
         endcase
      end
      if (execNow) begin
         unique case (execOp)
            lmw_pkg::OP_LOAD_BANK:
               next_bankSelector = instr[4:0];
            lmw_pkg::OP_LOAD_PCLATCH:
               next_programCounterHighLatch = instr[6:0];
            lmw_pkg::OP_LOAD_WORKING:
               next_working = instr[7:0];
            lmw_pkg::OP_STORE_FILE: begin
               next_memWe   = 1'b1;
               next_memData = working;
               if (fileAddr == lmw_pkg::IND_PORT0) begin
                  next_memAddr = indirectPointer[0];
               end else if (fileAddr == lmw_pkg::IND_PORT1) begin
                  next_memAddr = indirectPointer[1];
               end else begin
                  next_memAddr = {4'h0, bankSelector, fileAddr};
               end
            end
            lmw_pkg::OP_STORE_IND, lmw_pkg::OP_STORE_REL: begin
               next_memWe   = 1'b1;
               next_memData = working;
               next_memAddr = ptrBus.effAddr;
               next_indirectPointer[ptrSel] = ptrBus.nextPointer;
            end
            default: ;
         endcase
      end
      next_awready = !next_awHeld && !next_bvalid;
      next_wready  = !next_wHeld && !next_bvalid;
   end

   // Read channel
   always_comb begin
      next_rvalid  = s_axi_rvalid && !s_axi_rready;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = mapped(s_axi_araddr) ? lmw_pkg::RESP_OKAY : lmw_pkg::RESP_SLVERR;
         unique case (s_axi_araddr)
            lmw_pkg::REG_WORKING: next_rdata = {24'h000000, working};
            lmw_pkg::REG_BANK:    next_rdata = {27'h0000000, bankSelector};
            lmw_pkg::REG_PCLATCH: next_rdata = {25'h0000000, programCounterHighLatch};
            lmw_pkg::REG_PTR0:    next_rdata = {16'h0000, indirectPointer[0]};
            lmw_pkg::REG_PTR1:    next_rdata = {16'h0000, indirectPointer[1]};
            lmw_pkg::REG_FLAGS:   next_rdata = {24'h000000, flags};
            lmw_pkg::REG_MEMWR:   next_rdata = {8'h00, memData, memAddr};
            default:              next_rdata = 32'h00000000;
         endcase
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         awHeld        <= 1'b0;
         awAddrQ       <= 8'h00;
         wHeld         <= 1'b0;
         wDataQ        <= 32'h00000000;
         wStrbQ        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= lmw_pkg::RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= lmw_pkg::RESP_OKAY;
         working       <= lmw_pkg::RST_WORKING;
         bankSelector  <= lmw_pkg::RST_BANK;
         programCounterHighLatch <= lmw_pkg::RST_PCLATCH;
         indirectPointer[0] <= lmw_pkg::RST_PTR;
         indirectPointer[1] <= lmw_pkg::RST_PTR;
         flags         <= lmw_pkg::RST_FLAGS;
         memWe         <= 1'b0;
         memAddr       <= 16'h0000;
         memData       <= 8'h00;
      end else begin
         awHeld        <= next_awHeld;
         awAddrQ       <= next_awAddrQ;
         wHeld         <= next_wHeld;
         wDataQ        <= next_wDataQ;
         wStrbQ        <= next_wStrbQ;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
         working       <= next_working;
         bankSelector  <= next_bankSelector;
         programCounterHighLatch <= next_programCounterHighLatch;
         indirectPointer <= next_indirectPointer;
         flags         <= next_flags;
         memWe         <= next_memWe;
         memAddr       <= next_memAddr;
         memData       <= next_memData;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   bank_load_a: assert property (
      execNow && execOp == lmw_pkg::OP_LOAD_BANK |=>
      bankSelector == $past(instr[4:0]) && $stable(flags))
      else $error("bank selector not loaded");

   latch_load_a: assert property (
      execNow && execOp == lmw_pkg::OP_LOAD_PCLATCH |=>
      programCounterHighLatch == $past(instr[6:0]) && $stable(flags))
      else $error("program latch not loaded");

   working_load_a: assert property (
      execNow && execOp == lmw_pkg::OP_LOAD_WORKING |=>
      working == $past(instr[7:0]) && !memWe)
      else $error("working register not loaded");

   file_store_a: assert property (
      execNow && execOp == lmw_pkg::OP_STORE_FILE && fileAddr > 7'h01 |=>
      memWe && memData == $past(working)
      && memAddr == {4'h0, $past(bankSelector), $past(fileAddr)})
      else $error("file store wrong");

   pre_inc_a: assert property (
      execNow && execOp == lmw_pkg::OP_STORE_IND && instr[1:0] == 2'b00 && !ptrSel
      |=> indirectPointer[0] == $past(indirectPointer[0]) + 16'h0001
      && memAddr == indirectPointer[0])
      else $error("pre-increment store wrong");

   post_dec_a: assert property (
      execNow && execOp == lmw_pkg::OP_STORE_IND && instr[1:0] == 2'b11 && ptrSel
      |=> indirectPointer[1] == $past(indirectPointer[1]) - 16'h0001
      && memAddr == $past(indirectPointer[1]))
      else $error("post-decrement store wrong");

   rel_offset_a: assert property (
      execNow && execOp == lmw_pkg::OP_STORE_REL && !ptrSel |=>
      $stable(indirectPointer[0]) && memWe
      && memAddr == $past(indirectPointer[0]) + {{10{$past(instr[5])}}, $past(instr[5:0])})
      else $error("relative store wrong");

   ind_port_a: assert property (
      execNow && execOp == lmw_pkg::OP_STORE_FILE && fileAddr == lmw_pkg::IND_PORT1 |=>
      memWe && memAddr == $past(indirectPointer[1]))
      else $error("indirect port not redirected");

   ptr_wrap_a: assert property (
      execNow && execOp == lmw_pkg::OP_STORE_IND && instr[1:0] == 2'b10 && ptrSel
      && indirectPointer[1] == 16'hffff |=> indirectPointer[1] == 16'h0000)
      else $error("pointer did not wrap");

   flags_kept_a: assert property (
      execNow && (execOp == lmw_pkg::OP_STORE_IND || execOp == lmw_pkg::OP_STORE_REL)
      |=> $stable(flags))
      else $error("flags changed by store");

   one_cycle_a: assert property (
      execNow |=> s_axi_bvalid ##1 !memWe)
      else $error("execution not single cycle");

endmodule
`default_nettype wire

// ---- rtl/lmw_pkg.sv ----
/*
 Constants, register map and instruction layout for the literal and
 working-register move execution core.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package lmw_pkg;

   // Register byte offsets
   localparam logic [7:0] REG_INSTR   = 8'h00;
   localparam logic [7:0] REG_WORKING = 8'h04;
   localparam logic [7:0] REG_BANK    = 8'h08;
   localparam logic [7:0] REG_PCLATCH = 8'h0c;
   localparam logic [7:0] REG_PTR0    = 8'h10;
   localparam logic [7:0] REG_PTR1    = 8'h14;
   localparam logic [7:0] REG_FLAGS   = 8'h18;
   localparam logic [7:0] REG_MEMWR   = 8'h1c;

   // Opcode field of an instruction word, bits [15:12]
   localparam int         OP_LSB          = 12;
   localparam logic [3:0] OP_LOAD_BANK    = 4'h1;
   localparam logic [3:0] OP_LOAD_PCLATCH = 4'h2;
   localparam logic [3:0] OP_LOAD_WORKING = 4'h3;
   localparam logic [3:0] OP_STORE_FILE   = 4'h4;
   localparam logic [3:0] OP_STORE_IND    = 4'h5;
   localparam logic [3:0] OP_STORE_REL    = 4'h6;

   // Operand field positions
   localparam int PTR_SEL_BIT = 8;
   localparam int BANK_W      = 5;
   localparam int PCLATCH_W   = 7;
   localparam int FILE_W      = 7;
   localparam int OFFSET_W    = 6;
   localparam int PTR_W       = 16;

   // File addresses that act as the indirect access ports
   localparam logic [6:0] IND_PORT0 = 7'h00;
   localparam logic [6:0] IND_PORT1 = 7'h01;

   // Values after reset
   localparam logic [7:0]  RST_WORKING = 8'h00;
   localparam logic [4:0]  RST_BANK    = 5'h00;
   localparam logic [6:0]  RST_PCLATCH = 7'h00;
   localparam logic [15:0] RST_PTR     = 16'h0000;
   localparam logic [7:0]  RST_FLAGS   = 8'h00;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      MODE_PRE_INC  = 2'b00,
      MODE_PRE_DEC  = 2'b01,
      MODE_POST_INC = 2'b10,
      MODE_POST_DEC = 2'b11
   } lmw_mode_e;

endpackage

// ---- rtl/lmw_pointer_unit.sv ----
/*
 Pointer arithmetic for stores through an indirect pointer.
 Purely combinational; the core registers the results.
*/
`timescale 1ns/100ps
`default_nettype none
module lmw_pointer_unit (
   lmw_ptr_if.unit p
);
   logic [15:0] incPtr;
   logic [15:0] decPtr;
   logic [15:0] sextOffset;

   always_comb begin
      incPtr     = p.pointer + 16'h0001;
      decPtr     = p.pointer - 16'h0001;
      sextOffset = {{10{p.offset[5]}}, p.offset};
      if (p.relative) begin
         p.effAddr     = p.pointer + sextOffset;
         p.nextPointer = p.pointer;
      end else begin
         unique case (p.pointerUpdateMode)
            lmw_pkg::MODE_PRE_INC: begin
               p.effAddr     = incPtr;
               p.nextPointer = incPtr;
            end
            lmw_pkg::MODE_PRE_DEC: begin
               p.effAddr     = decPtr;
               p.nextPointer = decPtr;
            end
            lmw_pkg::MODE_POST_INC: begin
               p.effAddr     = p.pointer;
               p.nextPointer = incPtr;
            end
            lmw_pkg::MODE_POST_DEC: begin
               p.effAddr     = p.pointer;
               p.nextPointer = decPtr;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- rtl/lmw_ptr_if.sv ----
/*
 Carrier between the execution core and its pointer arithmetic unit.
 Assumes the core drives the request side combinationally.
*/
`timescale 1ns/100ps
`default_nettype none
interface lmw_ptr_if;
   logic [15:0]       pointer;
   lmw_pkg::lmw_mode_e pointerUpdateMode;
   logic              relative;
   logic [5:0]        offset;
   logic [15:0]       effAddr;
   logic [15:0]       nextPointer;

   modport core (output pointer, pointerUpdateMode, relative, offset,
                 input effAddr, nextPointer);
   modport unit (input pointer, pointerUpdateMode, relative, offset,
                 output effAddr, nextPointer);
endinterface
`default_nettype wire

// ---- testbench/test_literal_and_w_move_execution.sv ----
/*
 Self-checking testbench for the literal and working-register move core.
 Assumes the core answers on AXI4-Lite and reports stores on its mem* port.
*/
`timescale 1ns/100ps
`default_nettype none
module test_literal_and_w_move_execution;
   logic        core_clk;
   logic        sys_rst;
   logic [7:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [7:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic        memWe;
   logic [15:0] memAddr;
   logic [7:0]  memData;
   logic        lastWe;
   int          err_total;
   int          n_checks;

   lmw_move_core uut (
      .core_clk      (core_clk),
      .sys_rst       (sys_rst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awprot  (3'h0),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arprot  (3'h0),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .memWe         (memWe),
      .memAddr       (memAddr),
      .memData       (memData)
   );

   always #2 core_clk = ~core_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] ins(input logic [3:0] op, input logic [11:0] arg);
      return {16'h0, op, arg};
   endfunction

   // Write one word; lastWe is the store strobe at the response edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit awDone;
      bit wDone;
      awDone = 0;
      wDone = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge core_clk);
         if (!awDone && s_axi_awready === 1'b1) begin
            awDone = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wDone && s_axi_wready === 1'b1) begin
            wDone = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
      lastWe = memWe;
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, exp, "read data");
      check({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
   endtask

   task automatic exec(input logic [31:0] word);
      wr(lmw_pkg::REG_INSTR, word, lmw_pkg::RESP_OKAY);
   endtask

   task automatic test_reset;
      for (int a = 4; a <= 28; a += 4) begin
         rd_check(8'(a), 32'h0, lmw_pkg::RESP_OKAY);
      end
      rd_check(8'h20, 32'h0, lmw_pkg::RESP_SLVERR);
      rd_check(8'h05, 32'h0, lmw_pkg::RESP_SLVERR);
      wr(8'h24, 32'hffffffff, lmw_pkg::RESP_SLVERR);
      $display("test reset done");
   endtask

   task automatic test_literals;
      logic [7:0] vb [3] = '{8'h0f, 8'h00, 8'h0a};
      logic [7:0] vp [3] = '{8'h7f, 8'h00, 8'h55};
      logic [7:0] vw [3] = '{8'hff, 8'h00, 8'h5a};
      wr(lmw_pkg::REG_FLAGS, 32'h5a, lmw_pkg::RESP_OKAY);
      for (int i = 0; i < 3; i++) begin
         exec(ins(lmw_pkg::OP_LOAD_BANK, {4'h0, vb[i]}));
         rd_check(lmw_pkg::REG_BANK, {24'h0, vb[i]}, lmw_pkg::RESP_OKAY);
         exec(ins(lmw_pkg::OP_LOAD_PCLATCH, {4'h0, vp[i]}));
         rd_check(lmw_pkg::REG_PCLATCH, {24'h0, vp[i]}, lmw_pkg::RESP_OKAY);
         exec(ins(lmw_pkg::OP_LOAD_WORKING, {4'h0, vw[i]}));
         check({31'h0, lastWe}, 32'h0, "load wrote memory");
         rd_check(lmw_pkg::REG_WORKING, {24'h0, vw[i]}, lmw_pkg::RESP_OKAY);
      end
      rd_check(lmw_pkg::REG_FLAGS, 32'h5a, lmw_pkg::RESP_OKAY);
      $display("test literals done");
   endtask

   task automatic test_file_store;
      exec(ins(lmw_pkg::OP_LOAD_WORKING, 12'h0a5));
      exec(ins(lmw_pkg::OP_LOAD_BANK, 12'h003));
      exec(ins(lmw_pkg::OP_STORE_FILE, 12'h07f));
      check({31'h0, lastWe}, 32'h1, "file store strobe");
      check({16'h0, memAddr}, 32'h01ff, "file store address");
      rd_check(lmw_pkg::REG_MEMWR, 32'h00a501ff, lmw_pkg::RESP_OKAY);
      wr(lmw_pkg::REG_PTR1, 32'h1234, lmw_pkg::RESP_OKAY);
      wr(lmw_pkg::REG_PTR0, 32'hbeef, lmw_pkg::RESP_OKAY);
      exec(ins(lmw_pkg::OP_STORE_FILE, 12'h001));
      check({16'h0, memAddr}, 32'h1234, "port one redirect");
      exec(ins(lmw_pkg::OP_STORE_FILE, 12'h000));
      check({16'h0, memAddr}, 32'hbeef, "port zero redirect");
      check({24'h0, memData}, 32'ha5, "redirect data");
      rd_check(lmw_pkg::REG_PTR1, 32'h1234, lmw_pkg::RESP_OKAY);
      $display("test file store done");
   endtask

   task automatic test_modes;
      logic        sl [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
      logic [15:0] st [4] = '{16'hffff, 16'h0000, 16'hffff, 16'h0000};
      logic [15:0] ea [4] = '{16'h0000, 16'hffff, 16'hffff, 16'h0000};
      logic [15:0] np [4] = '{16'h0000, 16'hffff, 16'h0000, 16'hffff};
      logic [1:0]  md;
      logic [15:0] n2;
      logic [7:0]  pa;
      for (int i = 0; i < 4; i++) begin
         md = 2'(i);
         pa = sl[i] ? lmw_pkg::REG_PTR1 : lmw_pkg::REG_PTR0;
         wr(pa, {16'h0, st[i]}, lmw_pkg::RESP_OKAY);
         exec(ins(lmw_pkg::OP_LOAD_WORKING, 12'h0c0 + 12'(i)));
         exec(ins(lmw_pkg::OP_STORE_IND, {3'h0, sl[i], 6'h0, md}));
         check({31'h0, lastWe}, 32'h1, "indirect strobe");
         check({16'h0, memAddr}, {16'h0, ea[i]}, "indirect address");
         check({24'h0, memData}, 32'hc0 + 32'(i), "indirect data");
         rd_check(pa, {16'h0, np[i]}, lmw_pkg::RESP_OKAY);
         n2 = md[0] ? np[i] - 16'h1 : np[i] + 16'h1;
         exec(ins(lmw_pkg::OP_STORE_IND, {3'h0, sl[i], 6'h0, md}));
         check({16'h0, memAddr}, {16'h0, md[1] ? np[i] : n2}, "repeat address");
         rd_check(pa, {16'h0, n2}, lmw_pkg::RESP_OKAY);
      end
      rd_check(lmw_pkg::REG_FLAGS, 32'h5a, lmw_pkg::RESP_OKAY);
      $display("test modes done");
   endtask

   task automatic test_relative;
      logic        sl [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
      logic [15:0] st [4] = '{16'h1000, 16'h1000, 16'hfff0, 16'h0010};
      logic [5:0]  of [4] = '{6'h20, 6'h1f, 6'h1f, 6'h20};
      logic [15:0] ea [4] = '{16'h0fe0, 16'h101f, 16'h000f, 16'hfff0};
      logic [7:0]  pa;
      for (int i = 0; i < 4; i++) begin
         pa = sl[i] ? lmw_pkg::REG_PTR1 : lmw_pkg::REG_PTR0;
         wr(pa, {16'h0, st[i]}, lmw_pkg::RESP_OKAY);
         exec(ins(lmw_pkg::OP_STORE_REL, {3'h0, sl[i], 2'h0, of[i]}));
         check({31'h0, lastWe}, 32'h1, "relative strobe");
         check({16'h0, memAddr}, {16'h0, ea[i]}, "relative address");
         rd_check(pa, {16'h0, st[i]}, lmw_pkg::RESP_OKAY);
      end
      rd_check(lmw_pkg::REG_FLAGS, 32'h5a, lmw_pkg::RESP_OKAY);
      $display("test relative done");
   endtask

   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      err_total = 0;
      n_checks = 0;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      test_reset();
      test_literals();
      test_file_store();
      test_modes();
      test_relative();
      complete_run();
   end

   // Whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      $display("mismatch at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule
`default_nettype wire
